/* File: itr_pkg.sv */
// Shared constants and types for the two-wire target with ready window
package itr_pkg;
  // System clock
  localparam int SYS_CLK_HZ = 25_000_000;
  // Fastest allowed bit rate; bit time is rounded up so the rate stays under
  localparam int MAX_BIT_RATE_HZ = 1_000_000;
  localparam int BIT_CYC =
    (SYS_CLK_HZ + MAX_BIT_RATE_HZ - 1) / MAX_BIT_RATE_HZ;
  localparam int QTR_CYC = (BIT_CYC + 3) / 4;
  // Bus addresses
  localparam logic [6:0] DEV_ADDR       = 7'h56;
  localparam logic [6:0] ADDR_FLIP_MASK = 7'h01;
  localparam logic       RW_WRITE       = 1'h0;
  localparam logic       RW_READ        = 1'h1;
  // Special bytes
  localparam logic [7:0] INVALID_BYTE = 8'hEE;
  localparam logic [7:0] FORCE_BYTE   = 8'hFF;
  // Window timeout and force-window delay
  localparam int TIMEOUT_MS  = 250;
  localparam int TIMEOUT_CYC = TIMEOUT_MS * (SYS_CLK_HZ / 1000);
  localparam int TWAIT_US    = 100;
  localparam int TWAIT_CYC   = TWAIT_US * (SYS_CLK_HZ / 1_000_000);
  // Read data fetch time, during which the serial clock is stretched
  localparam int FETCH_CYC = 4;
  // Byte-wide memory map window
  localparam logic [15:0] MAP_BASE  = 16'h1000;
  localparam int          MAP_AW    = 4;
  localparam int          MAP_DEPTH = 1 << MAP_AW;
  localparam logic [3:0]  IDX_POWER = 4'h1;
  localparam logic [3:0]  IDX_MASK  = 4'h2;
  // Power settings fields and reset values
  localparam int          PWR_EVENT_BIT = 0;
  localparam int          PWR_TERM_BIT  = 1;
  localparam int          PWR_HALT_BIT  = 2;
  localparam logic [7:0]  PWR_RESET     = 8'h02;
  localparam logic [7:0]  MASK_RESET    = 8'h00;
  localparam logic [7:0]  MEM_RESET     = 8'h00;

  // Host byte-level operations
  typedef enum logic [1:0] {
    OP_START = 2'h0,
    OP_STOP  = 2'h1,
    OP_WRITE = 2'h2,
    OP_READ  = 2'h3
  } itr_op_e;

  // First byte of a transfer: address shifted left, direction appended
  function automatic logic [7:0] addr_byte(input logic [6:0] addr,
                                           input logic       rw);
    return {addr, rw};
  endfunction : addr_byte
endpackage : itr_pkg

/* File: itr_link_if.sv */
// Open-drain serial clock, data and ready wires between host and target
interface itr_link_if;
  logic dev_scl_o;
  logic dev_scl_oe;
  logic dev_sda_o;
  logic dev_sda_oe;
  logic dev_rdy_o;
  logic dev_rdy_oe;
  logic host_scl_o;
  logic host_scl_oe;
  logic host_sda_o;
  logic host_sda_oe;
  logic scl;
  logic sda;
  logic rdy;

  // Wired-AND with pull-up: any enabled low driver pulls the wire low
  assign scl = !((dev_scl_oe && !dev_scl_o) || (host_scl_oe && !host_scl_o));
  assign sda = !((dev_sda_oe && !dev_sda_o) || (host_sda_oe && !host_sda_o));
  assign rdy = !(dev_rdy_oe && !dev_rdy_o);

  modport target (
    input  scl,
    input  sda,
    output dev_scl_o,
    output dev_scl_oe,
    output dev_sda_o,
    output dev_sda_oe,
    output dev_rdy_o,
    output dev_rdy_oe
  );

  modport host (
    input  scl,
    input  sda,
    input  rdy,
    output host_scl_o,
    output host_scl_oe,
    output host_sda_o,
    output host_sda_oe
  );
endinterface : itr_link_if

/* File: itr_target.sv */
// Serial target with byte map, clock stretching and ready window control
// Summary of operation
// - Work at bit rates up to 1 Mbit/s
// - Answer own seven-bit address 0x56
// - Host forms address byte with direction bit
// - Also acknowledge address with bit zero flipped
// - Host never uses the flipped address; the bench sends it once to check that it is acknowledged
// - Stretch clock while fetching read data
// - Sixteen-bit register address, low byte first
// - One byte stored per address
// - Wide values little-endian at aligned addresses
// - Ready is open-drain, low while window open
// - Host times transfers from the ready line
// - Streaming opens a window every sensing cycle
// - Event mode opens window on enabled events
// - Return 0xEE for missing map or closed window
// - Close window after unserviced timeout
// - Stop closes window when terminate bit set
// - Write 0xFF then stop forces new window in event or halt mode
module itr_target #(
  parameter int         TIMEOUT_CYC = itr_pkg::TIMEOUT_CYC,
  parameter int         TWAIT_CYC   = itr_pkg::TWAIT_CYC,
  parameter int         FETCH_CYC   = itr_pkg::FETCH_CYC,
  parameter logic [6:0] DEV_ADDR    = itr_pkg::DEV_ADDR
) (
  input  wire logic       i_sys_clk,
  input  wire logic       i_arst_n,
  itr_link_if.target      link,
  input  wire logic       i_cycle_pulse,
  input  wire logic [7:0] i_events,
  output logic            o_window,
  output logic [7:0]      o_cfg_power,
  output logic [7:0]      o_cfg_mask
);
  localparam int TW = $clog2(TIMEOUT_CYC + 1);
  localparam int WW = $clog2(TWAIT_CYC + 1);
  localparam int FW = $clog2(FETCH_CYC + 1);
  localparam int AW = itr_pkg::MAP_AW;

  // Refuse counts the counters cannot serve
  if (TIMEOUT_CYC < 2 || TWAIT_CYC < 1 || FETCH_CYC < 1) begin : g_bad
    $error("itr_target: timing parameters out of range");
  end

  typedef enum logic [5:0] {
    ST_IDLE  = 6'h01,
    ST_RX    = 6'h02,
    ST_ACK   = 6'h04,
    ST_FETCH = 6'h08,
    ST_TX    = 6'h10,
    ST_RACK  = 6'h20
  } itr_st_e;

  itr_st_e          st_r, st_nxt;
  logic [3:0]       bit_r, bit_nxt;
  logic [7:0]       sh_r, sh_nxt;
  logic             sda_low_r, sda_low_nxt;
  logic             nack_r, nack_nxt;
  logic             addr_ph_r, rd_r, rsv_r;
  logic [1:0]       cnt_r;
  logic [15:0]      ptr_r;
  logic             force_r;
  logic [FW-1:0]    fetch_r;
  logic [TW-1:0]    tmo_r;
  logic [WW-1:0]    wait_r;
  logic             win_r;
  logic [7:0]       mem [itr_pkg::MAP_DEPTH];
  logic             scl_s1, scl_s2, scl_d;
  logic             sda_s1, sda_s2, sda_d;

  // Two-flop synchronisers plus one delay stage for edge finding
  always_ff @(posedge i_sys_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      {scl_s1, scl_s2, scl_d} <= 3'h7;
      {sda_s1, sda_s2, sda_d} <= 3'h7;
    end else begin
      {scl_s1, scl_s2, scl_d} <= {link.scl, scl_s1, scl_s2};
      {sda_s1, sda_s2, sda_d} <= {link.sda, sda_s1, sda_s2};
    end
  end

  // Bus events; sampling at 25 MHz leaves ample margin at 1 Mbit/s
  wire scl_rise  = scl_s2 & ~scl_d;
  wire scl_fall  = ~scl_s2 & scl_d;
  wire start_det = scl_s2 & scl_d & sda_d & ~sda_s2;
  wire stop_det  = scl_s2 & scl_d & ~sda_d & sda_s2;

  // Byte level decode
  wire       byte_done = (st_r == ST_RX) && scl_fall && (bit_r == 4'h8);
  wire       data_byte = byte_done && !addr_ph_r && !rd_r && !rsv_r;
  wire       addr_hit  = sh_r[7:1] == DEV_ADDR;
  wire       rsv_hit   =
    sh_r[7:1] == (DEV_ADDR ^ itr_pkg::ADDR_FLIP_MASK);
  wire       in_map    = ptr_r[15:AW] == itr_pkg::MAP_BASE[15:AW];
  wire [AW-1:0] idx    = ptr_r[AW-1:0];
  wire [7:0] rd_byte   = (win_r && in_map && !rsv_r) ? mem[idx]
                         : itr_pkg::INVALID_BYTE;
  wire       ptr_lo    = data_byte && (cnt_r == 2'h0);
  wire       ptr_hi    = data_byte && (cnt_r == 2'h1);
  wire       wr_data   = data_byte && (cnt_r == 2'h2);
  wire       wr_mem    = wr_data && win_r && in_map;
  wire       fetch_done = (st_r == ST_FETCH) &&
                          (fetch_r == FW'(FETCH_CYC - 1));
  wire       ptr_inc   = wr_data || fetch_done;

  // Window control
  wire [7:0] pwr       = mem[itr_pkg::IDX_POWER];
  wire [7:0] mask      = mem[itr_pkg::IDX_MASK];
  wire       ev_mode   = pwr[itr_pkg::PWR_EVENT_BIT];
  wire       halt_mode = pwr[itr_pkg::PWR_HALT_BIT];
  wire       streaming = !ev_mode && !halt_mode;
  wire       force_set = ptr_lo && (sh_r == itr_pkg::FORCE_BYTE);
  wire       force_go  = stop_det && force_r &&
                         (ev_mode || halt_mode);
  wire       wait_fire = (wait_r == WW'(1));
  // Halt opens nothing from a sensing cycle; event mode needs a masked hit
  wire       ev_hit    = ev_mode && !halt_mode &&
                         (|(i_events & mask));
  wire       cyc_open  = i_cycle_pulse &&
                         (streaming || ev_hit);
  wire       win_open  = cyc_open || wait_fire;
  wire       tmo_hit   = win_r && (tmo_r == TW'(TIMEOUT_CYC - 1));
  wire       win_close = tmo_hit ||
                         (stop_det && pwr[itr_pkg::PWR_TERM_BIT]);

  // Bit and byte sequencer; start and stop override every state
  always_comb begin
    st_nxt      = st_r;
    bit_nxt     = bit_r;
    sh_nxt      = sh_r;
    sda_low_nxt = sda_low_r;
    nack_nxt    = nack_r;
    case (st_r)
      ST_IDLE: begin
      end
      ST_RX: begin
        if (scl_rise) begin
          sh_nxt  = {sh_r[6:0], sda_s2};
          bit_nxt = bit_r + 4'h1;
        end else if (byte_done) begin
          if (addr_ph_r && !(addr_hit || rsv_hit)) begin
            st_nxt = ST_IDLE;
          end else begin
            st_nxt      = ST_ACK;
            sda_low_nxt = 1'h1;
          end
        end
      end
      ST_ACK: begin
        if (scl_fall) begin
          sda_low_nxt = 1'h0;
          bit_nxt     = 4'h0;
          st_nxt      = rd_r ? ST_FETCH : ST_RX;
        end
      end
      ST_FETCH: begin
        if (fetch_done) begin
          st_nxt      = ST_TX;
          sh_nxt      = rd_byte;
          sda_low_nxt = ~rd_byte[7];
          bit_nxt     = 4'h0;
        end
      end
      ST_TX: begin
        if (scl_fall) begin
          if (bit_r == 4'h7) begin
            st_nxt      = ST_RACK;
            sda_low_nxt = 1'h0;
          end else begin
            sh_nxt      = {sh_r[6:0], 1'h0};
            sda_low_nxt = ~sh_r[6];
            bit_nxt     = bit_r + 4'h1;
          end
        end
      end
      ST_RACK: begin
        if (scl_rise) begin
          nack_nxt = sda_s2;
        end else if (scl_fall) begin
          st_nxt = nack_r ? ST_IDLE : ST_FETCH;
        end
      end
      default: begin
        st_nxt = ST_IDLE;
      end
    endcase
    if (start_det) begin
      st_nxt      = ST_RX;
      bit_nxt     = 4'h0;
      sda_low_nxt = 1'h0;
    end else if (stop_det) begin
      st_nxt      = ST_IDLE;
      sda_low_nxt = 1'h0;
    end
  end

  // Sequencer registers
  always_ff @(posedge i_sys_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      st_r      <= ST_IDLE;
      bit_r     <= 4'h0;
      sh_r      <= 8'h00;
      sda_low_r <= 1'h0;
      nack_r    <= 1'h0;
    end else begin
      st_r      <= st_nxt;
      bit_r     <= bit_nxt;
      sh_r      <= sh_nxt;
      sda_low_r <= sda_low_nxt;
      nack_r    <= nack_nxt;
    end
  end

  // Transfer context: address phase, direction, reserved target, byte count
  always_ff @(posedge i_sys_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      addr_ph_r <= 1'h0;
      rd_r      <= 1'h0;
      rsv_r     <= 1'h0;
      cnt_r     <= 2'h0;
    end else if (start_det) begin
      addr_ph_r <= 1'h1;
      rd_r      <= 1'h0;
      cnt_r     <= 2'h0;
    end else if (byte_done && addr_ph_r) begin
      addr_ph_r <= 1'h0;
      rd_r      <= sh_r[0];
      rsv_r     <= !addr_hit; // Reserved address is acked; its reads give 0xEE but still step the pointer
    end else if (data_byte && cnt_r != 2'h2) begin
      cnt_r <= cnt_r + 2'h1;
    end
  end

  // Register pointer survives repeated start, so reads follow an address
  always_ff @(posedge i_sys_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      ptr_r <= 16'h0000;
    end else if (ptr_lo) begin
      ptr_r[7:0] <= sh_r;
    end else if (ptr_hi) begin
      ptr_r[15:8] <= sh_r;
    end else if (ptr_inc) begin
      ptr_r <= ptr_r + 16'h0001;
    end
  end

  // Fetch counter; the clock is held low for the whole fetch
  always_ff @(posedge i_sys_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      fetch_r <= '0;
    end else begin
      fetch_r <= (st_r == ST_FETCH) ? fetch_r + FW'(1) : '0;
    end
  end

  // Byte map; wide values sit low byte at the lower aligned address
  always_ff @(posedge i_sys_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      for (int i = 0; i < itr_pkg::MAP_DEPTH; i++) begin
        mem[i] <= itr_pkg::MEM_RESET;
      end
      mem[itr_pkg::IDX_POWER] <= itr_pkg::PWR_RESET;
      mem[itr_pkg::IDX_MASK]  <= itr_pkg::MASK_RESET;
    end else if (wr_mem) begin
      mem[idx] <= sh_r;
    end
  end

  // Force request: one 0xFF byte and a stop; a later byte cancels it
  always_ff @(posedge i_sys_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      force_r <= 1'h0;
    end else if (force_set) begin
      force_r <= 1'h1;
    end else if (start_det || stop_det || data_byte) begin
      force_r <= 1'h0;
    end
  end

  // Delay between force request and window opening
  always_ff @(posedge i_sys_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      wait_r <= '0;
    end else if (force_go) begin
      wait_r <= WW'(TWAIT_CYC);
    end else if (wait_r != '0) begin
      wait_r <= wait_r - WW'(1);
    end
  end

  // Window flag and its timeout; a new opening wins over a close
  always_ff @(posedge i_sys_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      win_r <= 1'h0;
      tmo_r <= '0;
    end else begin
      win_r <= win_open ? 1'h1 : (win_close ? 1'h0 : win_r);
      tmo_r <= (win_r && !win_open && !win_close) ? tmo_r + TW'(1) : '0;
    end
  end

  // Clock held one cycle into the first bit, so data leads the release
  wire       stretch   = (st_r == ST_FETCH) ||
                         ((st_r == ST_TX) && (fetch_r != '0));

  // Open-drain drivers only ever pull low
  assign link.dev_scl_o  = 1'h0;
  assign link.dev_scl_oe = stretch;
  assign link.dev_sda_o  = 1'h0;
  assign link.dev_sda_oe = sda_low_r;
  assign link.dev_rdy_o  = 1'h0;
  assign link.dev_rdy_oe = win_r;
  assign o_window        = win_r;
  assign o_cfg_power     = pwr;
  assign o_cfg_mask      = mask;
endmodule : itr_target

/* File: itr_host.sv */
// Bus controller end: byte-level start, stop, write and read operations
module itr_host #(
  parameter int QTR_CYC = itr_pkg::QTR_CYC
) (
  input  wire logic            i_sys_clk,
  input  wire logic            i_arst_n,
  itr_link_if.host             link,
  input  wire logic            i_op_valid,
  input  wire itr_pkg::itr_op_e i_op,
  input  wire logic [7:0]      i_op_data,
  input  wire logic            i_op_last,
  input  wire logic            i_wait_rdy,
  output logic                 o_op_ready,
  output logic                 o_done,
  output logic [7:0]           o_rd_data,
  output logic                 o_ack_seen,
  output logic                 o_rdy_seen
);
  localparam int QW = $clog2(QTR_CYC + 1);

  // Four quarters must not beat the 1 Mbit/s limit
  if (QTR_CYC < 1 || 4 * QTR_CYC < itr_pkg::BIT_CYC) begin : g_bad
    $error("itr_host: quarter period too short");
  end

  typedef enum logic [2:0] {
    H_IDLE = 3'h1,
    H_WAIT = 3'h2,
    H_RUN  = 3'h4
  } itr_hst_e;

  itr_hst_e         st_r;
  itr_pkg::itr_op_e kind_r;
  logic [1:0]       step_r;
  logic [QW-1:0]    q_r;
  logic [3:0]       bitn_r;
  logic [8:0]       tx_r, rx_r;
  logic             scl_low_r, sda_low_r;
  logic             done_r, ack_r;
  logic [7:0]       rd_r;
  logic             scl_s1, scl_s2, sda_s1, sda_s2, rdy_s1, rdy_s2;

  // Two-flop synchronisers for the wires
  always_ff @(posedge i_sys_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      {scl_s1, scl_s2, sda_s1, sda_s2, rdy_s1, rdy_s2} <= 6'h3F;
    end else begin
      {scl_s1, scl_s2} <= {link.scl, scl_s1};
      {sda_s1, sda_s2} <= {link.sda, sda_s1};
      {rdy_s1, rdy_s2} <= {link.rdy, rdy_s1};
    end
  end

  // Quarter steps; step 1 also waits for the target to free the clock
  wire is_bit   = (kind_r == itr_pkg::OP_WRITE) ||
                  (kind_r == itr_pkg::OP_READ);
  wire is_stop  = (kind_r == itr_pkg::OP_STOP);
  wire q_end    = (q_r == QW'(QTR_CYC - 1));
  wire step_adv = (st_r == H_RUN) && q_end &&
                  (step_r != 2'h1 || scl_s2);
  wire finish   = step_adv && ((step_r == 2'h2 && is_stop) ||
                  (step_r == 2'h3 && !(is_bit && bitn_r > 4'h1)));
  wire accept   = (st_r == H_IDLE) && i_op_valid;
  wire hold_rdy = (i_op == itr_pkg::OP_START) && i_wait_rdy &&
                  rdy_s2;
  wire go       = (accept && !hold_rdy) || ((st_r == H_WAIT) && !rdy_s2);
  wire [8:0] tx_load = (i_op == itr_pkg::OP_WRITE) ? {i_op_data, 1'h1}
                                                  : {8'hFF, i_op_last};

  // Operation state
  always_ff @(posedge i_sys_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      st_r   <= H_IDLE;
      kind_r <= itr_pkg::OP_STOP;
    end else if (accept) begin
      st_r   <= hold_rdy ? H_WAIT : H_RUN;
      kind_r <= i_op;
    end else if (go) begin
      st_r <= H_RUN;
    end else if (finish) begin
      st_r <= H_IDLE;
    end
  end

  // Quarter counter and step index
  always_ff @(posedge i_sys_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      q_r    <= '0;
      step_r <= 2'h0;
    end else if (go) begin
      q_r    <= '0;
      step_r <= 2'h0;
    end else if (st_r == H_RUN) begin
      q_r    <= (q_end || (step_r == 2'h1 && !scl_s2)) ? '0 : q_r + QW'(1);
      step_r <= step_adv ? step_r + 2'h1 : step_r;
    end
  end

  // Wire drive per step: data bits change only while the clock is low; start and stop change it with the clock high
  always_ff @(posedge i_sys_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      scl_low_r <= 1'h0;
      sda_low_r <= 1'h0;
      tx_r      <= 9'h1FF;
      rx_r      <= 9'h000;
      bitn_r    <= 4'h0;
    end else if (accept) begin
      tx_r      <= tx_load;
      bitn_r    <= 4'h9;
      sda_low_r <= (i_op == itr_pkg::OP_STOP) ||
                   (i_op != itr_pkg::OP_START && !tx_load[8]);
    end else if (step_adv) begin
      case (step_r)
        2'h0: scl_low_r <= 1'h0;
        2'h1: begin
          rx_r <= {rx_r[7:0], sda_s2};
          if (!is_bit) begin
            sda_low_r <= !is_stop; // Start pulls data, stop frees it
          end
        end
        2'h2: scl_low_r <= !is_stop;
        default: begin
          if (is_bit && bitn_r > 4'h1) begin
            bitn_r    <= bitn_r - 4'h1;
            tx_r      <= {tx_r[7:0], 1'h1};
            sda_low_r <= ~tx_r[7];
          end
        end
      endcase
    end
  end

  // Results of a byte operation
  always_ff @(posedge i_sys_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      done_r <= 1'h0;
      rd_r   <= 8'h00;
      ack_r  <= 1'h0;
    end else begin
      done_r <= finish;
      if (finish && is_bit) begin
        rd_r  <= rx_r[8:1];
        ack_r <= ~rx_r[0];
      end
    end
  end

  assign link.host_scl_o  = 1'h0;
  assign link.host_scl_oe = scl_low_r;
  assign link.host_sda_o  = 1'h0;
  assign link.host_sda_oe = sda_low_r;
  assign o_op_ready       = (st_r == H_IDLE);
  assign o_done           = done_r;
  assign o_rd_data        = rd_r;
  assign o_ack_seen       = ack_r;
  assign o_rdy_seen       = ~rdy_s2;
endmodule : itr_host

/* File: itr_properties.sv */
// Concurrent checks on the link wires between host and target ends
module itr_properties (
  input wire logic i_sys_clk,
  input wire logic i_arst_n,
  input wire logic dev_scl_o,
  input wire logic dev_scl_oe,
  input wire logic dev_sda_o,
  input wire logic dev_sda_oe,
  input wire logic dev_rdy_o,
  input wire logic dev_rdy_oe,
  input wire logic scl,
  input wire logic sda,
  input wire logic rdy
);
  default clocking cb @(posedge i_sys_clk);
  endclocking
  default disable iff (!i_arst_n);

  // Open-drain pins may only ever pull low
  od_low_a: assert property (
    !dev_rdy_o && !dev_scl_o && !dev_sda_o)
    else $error("open-drain pin driven high");
  // A window opens for more than a glitch
  win_hold_a: assert property ($fell(rdy) |=> !rdy)
    else $error("ready window too short");
  // Windows close with the bus idle, after a stop or a timeout
  win_close_a: assert property ($rose(rdy) |-> scl && sda)
    else $error("window closed with bus busy");
  // Stretching only extends a low clock, never makes an edge
  stretch_low_a: assert property ($rose(dev_scl_oe) |-> !scl)
    else $error("stretch began on high clock");
  // Fetch holds the clock for a bounded time
  stretch_len_a: assert property (
    $rose(dev_scl_oe) |-> dev_scl_oe [*4] ##[1:40] !dev_scl_oe)
    else $error("stretch length out of range");
  // Target data only moves while the clock is low
  sda_move_a: assert property ($changed(dev_sda_oe) |-> !scl)
    else $error("target data moved on high clock");
  // Data stays put just after a rising clock
  sda_hold_a: assert property (
    $rose(scl) |=> $stable(dev_sda_oe) [*3])
    else $error("target data unstable after clock rise");
  // Target never holds data low longer than one byte
  sda_len_a: assert property (
    $rose(dev_sda_oe) |-> ##[1:400] !dev_sda_oe)
    else $error("target held data low too long");
endmodule : itr_properties

/* File: tb.sv */
// Bench: host end drives the target end over the shared link
`define CHK(a, b) begin samples_checked++; if ((a) !== (b)) begin \
  bad_count++; $display("unexpected at %0t: %h", $time, a); end end
module tb;
  timeunit 1ns;
  timeprecision 1ps;
  // Long enough for a full read-back inside one window
  localparam int TO = 6000;
  localparam int TW = 20;
  localparam logic [7:0] WA = {itr_pkg::DEV_ADDR, itr_pkg::RW_WRITE};
  localparam logic [7:0] RA = {itr_pkg::DEV_ADDR, itr_pkg::RW_READ};
  localparam logic [31:0] VAL = 32'hC33C5AA5;
  logic             i_sys_clk;
  logic             i_arst_n;
  logic             cyc_pulse;
  logic [7:0]       ev;
  logic             op_valid;
  itr_pkg::itr_op_e op;
  logic [7:0]       op_data;
  logic             op_last;
  logic             wait_rdy;
  logic             done;
  logic             op_ready;
  logic             ack_seen;
  logic             rdy_seen;
  logic             window;
  logic [7:0]       rd_data;
  logic [7:0]       cfg_power;
  logic [7:0]       cfg_mask;
  int               bad_count;
  int               samples_checked;

  itr_link_if lnk ();
  itr_target #(.TIMEOUT_CYC(TO), .TWAIT_CYC(TW)) u_itr_target (
    .i_sys_clk(i_sys_clk), .i_arst_n(i_arst_n), .link(lnk),
    .i_cycle_pulse(cyc_pulse), .i_events(ev), .o_window(window),
    .o_cfg_power(cfg_power), .o_cfg_mask(cfg_mask));
  itr_host u_itr_host (
    .i_sys_clk(i_sys_clk), .i_arst_n(i_arst_n), .link(lnk),
    .i_op_valid(op_valid), .i_op(op), .i_op_data(op_data),
    .i_op_last(op_last), .i_wait_rdy(wait_rdy), .o_op_ready(op_ready),
    .o_done(done), .o_rd_data(rd_data), .o_ack_seen(ack_seen),
    .o_rdy_seen(rdy_seen));
  itr_properties u_itr_properties (
    .i_sys_clk(i_sys_clk), .i_arst_n(i_arst_n),
    .dev_scl_o(lnk.dev_scl_o), .dev_scl_oe(lnk.dev_scl_oe),
    .dev_sda_o(lnk.dev_sda_o), .dev_sda_oe(lnk.dev_sda_oe),
    .dev_rdy_o(lnk.dev_rdy_o), .dev_rdy_oe(lnk.dev_rdy_oe),
    .scl(lnk.scl), .sda(lnk.sda), .rdy(lnk.rdy));

  // Prints the counts and the verdict, then ends the run
  task automatic stop_test;
    $display("checks %0d mismatches %0d", samples_checked, bad_count);
    if (bad_count == 0 && samples_checked > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask : stop_test

  // One host operation; the host has no queue, so wait for done
  task automatic hop(input itr_pkg::itr_op_e o, input logic [7:0] d,
                     input logic l);
    int n;
    n = 0;
    @(posedge i_sys_clk);
    op_valid <= 1'b1;
    op <= o;
    op_data <= d;
    op_last <= l;
    @(posedge i_sys_clk);
    op_valid <= 1'b0;
    while (done !== 1'b1) begin
      @(negedge i_sys_clk);
      n++;
      if (n > 4000) begin
        bad_count++;
        stop_test();
      end
    end
    `CHK(op_ready, 1'b1)
  endtask : hop

  task automatic wb(input logic [7:0] d);
    hop(itr_pkg::OP_WRITE, d, 1'b0);
  endtask : wb

  task automatic rb(input logic l);
    hop(itr_pkg::OP_READ, 8'h00, l);
  endtask : rb

  task automatic st;
    hop(itr_pkg::OP_START, 8'h00, 1'b0);
  endtask : st

  task automatic sp;
    hop(itr_pkg::OP_STOP, 8'h00, 1'b0);
  endtask : sp

  // Start, address for write, then pointer low byte first
  task automatic setp(input logic [15:0] p);
    st();
    wb(WA);
    `CHK(ack_seen, 1'b1)
    wb(p[7:0]);
    wb(p[15:8]);
  endtask : setp

  // One sensing cycle with the given event flags
  task automatic pulse(input logic [7:0] e);
    @(posedge i_sys_clk);
    cyc_pulse <= 1'b1;
    ev <= e;
    @(posedge i_sys_clk);
    cyc_pulse <= 1'b0;
    repeat (2) @(negedge i_sys_clk);
  endtask : pulse

  initial begin
    i_sys_clk = 1'b0;
    forever #20 i_sys_clk = ~i_sys_clk;
  end

  // Main sequence
  initial begin
    i_arst_n = 1'b0;
    cyc_pulse = 1'b0;
    ev = 8'h00;
    op_valid = 1'b0;
    op = itr_pkg::OP_START;
    op_data = 8'h00;
    op_last = 1'b0;
    wait_rdy = 1'b0;
    bad_count = 0;
    samples_checked = 0;
    repeat (12) @(posedge i_sys_clk);
    i_arst_n <= 1'b1;
    repeat (3) @(negedge i_sys_clk);
    `CHK(cfg_power, itr_pkg::PWR_RESET)
    `CHK(cfg_mask, itr_pkg::MASK_RESET)
    `CHK(lnk.rdy, 1'b1)
    // A read with no window open gives the invalid byte
    setp(16'h1001);
    st();
    wb(RA);
    rb(1'b1);
    `CHK(rd_data, itr_pkg::INVALID_BYTE)
    sp();
    // Foreign address refused, flipped address acknowledged
    st();
    wb(8'hAA);
    `CHK(ack_seen, 1'b0)
    sp();
    st();
    wb(WA ^ 8'h02);
    `CHK(ack_seen, 1'b1)
    sp();
    // Streaming window: write a word, read it back, stop closes
    pulse(8'h00);
    `CHK(window, 1'b1)
    `CHK(lnk.rdy, 1'b0)
    @(posedge i_sys_clk);
    wait_rdy <= 1'b1;
    setp(16'h1004);
    for (int i = 0; i < 4; i++) wb(VAL[8*i +: 8]);
    setp(16'h1004);
    st();
    wb(RA);
    for (int i = 0; i < 4; i++) begin
      rb(i == 3);
      `CHK(rd_data, VAL[8*i +: 8])
    end
    sp();
    repeat (10) @(negedge i_sys_clk);
    `CHK(window, 1'b0)
    // Event mode with one enabled event, stop still closes
    pulse(8'h00);
    setp(16'h1001);
    wb(8'h03);
    wb(8'h04);
    sp();
    repeat (10) @(negedge i_sys_clk);
    `CHK(cfg_power, 8'h03)
    `CHK(cfg_mask, 8'h04)
    `CHK(window, 1'b0)
    pulse(8'h01);
    `CHK(window, 1'b0)
    pulse(8'h04);
    `CHK(window, 1'b1)
    repeat (TO + 10) @(negedge i_sys_clk);
    `CHK(window, 1'b0)
    // Force byte then stop opens a window after the delay
    @(posedge i_sys_clk);
    wait_rdy <= 1'b0;
    st();
    wb(WA);
    wb(itr_pkg::FORCE_BYTE);
    sp();
    `CHK(window, 1'b0)
    repeat (TW + 10) @(negedge i_sys_clk);
    `CHK(window, 1'b1)
    `CHK(rdy_seen, 1'b1)
    // Terminate bit clear: stop keeps the window; halt ignores events
    setp(16'h1001);
    wb(8'h04);
    sp();
    `CHK(cfg_power, 8'h04)
    `CHK(window, 1'b1)
    setp(16'h1001);
    wb(8'h06);
    sp();
    repeat (10) @(negedge i_sys_clk);
    `CHK(window, 1'b0)
    pulse(8'h04);
    `CHK(window, 1'b0)
    // Force byte still opens a window in halt mode
    st();
    wb(WA);
    wb(itr_pkg::FORCE_BYTE);
    sp();
    repeat (TW + 10) @(negedge i_sys_clk);
    `CHK(window, 1'b1)
    stop_test();
  end
endmodule : tb
